//--- verilog/tx_cmd_pkg.sv
/*
 * shared constants of the transmit buffer command parser: command word
 * field positions, alignment codes, sizes and reset values.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package tx_cmd_pkg;

  localparam int           A_IOC_BIT       = 31;
  localparam int           A_ALIGN_HI      = 25;
  localparam int           A_ALIGN_LO      = 24;
  localparam int           A_OFS_HI        = 20;
  localparam int           A_OFS_LO        = 16;
  localparam int           A_FIRST_BIT     = 13;
  localparam int           A_LAST_BIT      = 12;
  localparam int           A_SIZE_HI       = 10;
  localparam int           A_SIZE_LO       = 0;

  localparam int           B_TAG_HI        = 31;
  localparam int           B_TAG_LO        = 16;
  localparam int           B_NOCRC_BIT     = 13;
  localparam int           B_NOPAD_BIT     = 12;
  localparam int           B_LEN_HI        = 10;
  localparam int           B_LEN_LO        = 0;

  localparam logic [1:0]   ALIGN_4         = 2'h0;
  localparam logic [1:0]   ALIGN_16        = 2'h1;
  localparam logic [1:0]   ALIGN_32        = 2'h2;

  localparam int           LEN_W           = 11;
  localparam int           MIN_FRAME_BYTES = 64;

  localparam logic [31:0]  WORD_RST        = 32'h0000_0000;
  localparam logic [10:0]  LEN_RST         = 11'h000;
  localparam logic [15:0]  TAG_RST         = 16'h0000;

endpackage : tx_cmd_pkg

//--- verilog/word_assembler.sv
/*
 * joins two 16-bit host writes into one 32-bit word, low half first.
 * assumes host strobes on the clk domain, one cycle long.
 */
`timescale 1ns/10ps
module word_assembler (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        half_wr,
  input  wire logic [15:0] half_data,
  input  wire logic        resync,
  output logic             word_valid,
  output logic [31:0]      word_data
);

  logic        high_next;
  logic [15:0] low_half;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      high_next <= 1'b0;
      low_half  <= 16'h0000;
    end else if (resync) begin
      high_next <= 1'b0;
    end else if (half_wr) begin
      high_next <= !high_next;
      if (!high_next) low_half <= half_data;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      word_valid <= 1'b0;
      word_data  <= tx_cmd_pkg::WORD_RST;
    end else begin
      word_valid <= half_wr && high_next && !resync;
      if (half_wr && high_next) word_data <= {half_data, low_half};
    end
  end

endmodule : word_assembler

//--- verilog/lane_packer.sv
/*
 * computes byte enables for one payload word from start lane and the
 * number of bytes still owed to the buffer.
 * assumes pure combinational use inside the parser.
 */
`timescale 1ns/10ps
module lane_packer (
  input  wire logic [1:0]  first_lane,
  input  wire logic        is_first,
  input  wire logic [10:0] bytes_left,
  output logic [3:0]       lane_en,
  output logic [2:0]       lane_cnt
);

  always_comb begin
    logic [2:0] start;
    logic [3:0] avail;
    start    = is_first ? {1'b0, first_lane} : 3'd0;
    avail    = 4'(3'd4 - start);
    lane_cnt = (bytes_left < 11'(avail)) ? bytes_left[2:0] : avail[2:0];
    lane_en  = 4'h0;
    for (int i = 0; i < 4; i++) begin
      if (3'(i) >= start && 3'(i) < 3'(start + lane_cnt)) lane_en[i] = 1'b1;
    end
  end

endmodule : lane_packer

//--- verilog/tx_buffer_command_parser.sv
/*
 * transmit buffer parser: takes host buffer words (command A, command B,
 * payload, filler), strips offsets and filler, forwards payload with
 * byte enables to the transmit data fifo and checks packet length.
 * assumes the fifo accepts one word per cycle; no back-pressure.
 */
//Contract
//- bit 13 of command A marks first segment
//- bit 12 of command A marks final segment
//- size plus alignment give trailing filler words
//- summed sizes unequal packet length sets error
//- tag copied to status unchanged
//- crc disable bit suppresses crc; the code ignores it while pad disable is set
//- pad disable keeps crc, no padding
//- payload starts at third word
//- offset low bits select first lane
//- offset bits 4:2 skip whole words
//- unused trailing bytes not forwarded
//- filler words discarded before fifo
//- any start, end, first and last length
//- only payload words reach the fifo; command A and the first command B also go out on fifo_cmd_word
//- at most six overhead bytes per buffer
//- alignment code 00/01/10 gives 4/16/32 bytes
//- completion request raises done after loading
//- command B stored only on first segment
//- two 16-bit writes form one word
`timescale 1ns/10ps
module tx_buffer_command_parser (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        host_wr,
  input  wire logic [15:0] host_data,
  input  wire logic        store_forward_select,
  output logic             fifo_cmd_valid,
  output logic [31:0]      fifo_cmd_word,
  output logic             fifo_data_valid,
  output logic [31:0]      fifo_data_word,
  output logic [3:0]       fifo_byte_en,
  output logic             frame_end,
  output logic             crc_disable,
  output logic             pad_disable,
  output logic [15:0]      status_tag,
  output logic             transmit_error_flag,
  output logic             transmit_done_flag,
  output logic             first_segment_flag,
  output logic             last_segment_flag,
  output logic             oversize_flag
);

  localparam logic [11:0] SF_LIMIT = 12'd2036;

  typedef enum logic [4:0] {
    S_CMDA = 5'b00001,
    S_CMDB = 5'b00010,
    S_SKIP = 5'b00100,
    S_DATA = 5'b01000,
    S_FILL = 5'b10000
  } state_e;

  state_e      state;
  logic        word_valid;
  logic [31:0] word;
  logic [31:0] cmd_a;
  logic [10:0] bytes_left;
  logic [2:0]  skip_cnt;
  logic [3:0]  fill_cnt;
  logic        first_word;
  logic [11:0] len_sum;
  logic [11:0] fifo_used;
  logic [10:0] pkt_len;
  logic [3:0]  lane_en;
  logic [2:0]  lane_cnt;
  logic [3:0]  fill_words;

  // filler words = words to next boundary after the buffer's last word
  function automatic logic [3:0] filler(input logic [31:0] a);
    logic [12:0] span;
    logic [10:0] words;
    logic [3:0]  mask;
    // start lane, not size bits: a late first byte can spill into one more word
    span  = 13'(a[tx_cmd_pkg::A_OFS_LO+1:tx_cmd_pkg::A_OFS_LO])
          + 13'(a[tx_cmd_pkg::A_SIZE_HI:tx_cmd_pkg::A_SIZE_LO]) + 13'd3;
    words = 11'(span >> 2) + 11'(a[tx_cmd_pkg::A_OFS_HI:tx_cmd_pkg::A_OFS_LO+2]);
    unique case (a[tx_cmd_pkg::A_ALIGN_HI:tx_cmd_pkg::A_ALIGN_LO])
      tx_cmd_pkg::ALIGN_16: mask = 4'h3;
      tx_cmd_pkg::ALIGN_32: mask = 4'h7;
      default:              mask = 4'h0;
    endcase
    // command words count toward the boundary too
    filler = 4'((4'h0 - 4'(words + 11'd2)) & mask);
  endfunction : filler

  word_assembler u_asm (
    .clk        (clk),
    .nrst       (nrst),
    .half_wr    (host_wr),
    .half_data  (host_data),
    .resync     (1'b0),
    .word_valid (word_valid),
    .word_data  (word)
  );

  lane_packer u_lane (
    .first_lane (cmd_a[tx_cmd_pkg::A_OFS_LO+1:tx_cmd_pkg::A_OFS_LO]),
    .is_first   (first_word),
    .bytes_left (bytes_left),
    .lane_en    (lane_en),
    .lane_cnt   (lane_cnt)
  );

  assign fill_words = filler(cmd_a);

  // buffer walk
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state      <= S_CMDA;
      cmd_a      <= tx_cmd_pkg::WORD_RST;
      bytes_left <= tx_cmd_pkg::LEN_RST;
      skip_cnt   <= 3'd0;
      fill_cnt   <= 4'd0;
      first_word <= 1'b0;
    end else if (word_valid) begin
      unique case (state)
        S_CMDA: begin
          cmd_a      <= word;
          bytes_left <= word[tx_cmd_pkg::A_SIZE_HI:tx_cmd_pkg::A_SIZE_LO];
          skip_cnt   <= word[tx_cmd_pkg::A_OFS_HI:tx_cmd_pkg::A_OFS_LO+2];
          first_word <= 1'b1;
          state      <= S_CMDB;
        end
        S_CMDB: begin
          if (skip_cnt != 3'd0) state <= S_SKIP;
          else if (bytes_left != 11'd0) state <= S_DATA;
          else if (fill_words != 4'd0) state <= S_FILL;
          else state <= S_CMDA;
          fill_cnt <= fill_words;
        end
        S_SKIP: begin
          skip_cnt <= skip_cnt - 3'd1;
          if (skip_cnt == 3'd1) begin
            if (bytes_left != 11'd0) state <= S_DATA;
            else if (fill_cnt != 4'd0) state <= S_FILL;
            else state <= S_CMDA;
          end
        end
        S_DATA: begin
          first_word <= 1'b0;
          bytes_left <= bytes_left - 11'(lane_cnt);
          if (bytes_left == 11'(lane_cnt)) begin
            state <= (fill_cnt != 4'd0) ? S_FILL : S_CMDA;
          end
        end
        S_FILL: begin
          fill_cnt <= fill_cnt - 4'd1;
          if (fill_cnt == 4'd1) state <= S_CMDA;
        end
        default: state <= S_CMDA;
      endcase
    end
  end

  // forwarding to the transmit data fifo
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fifo_cmd_valid  <= 1'b0;
      fifo_cmd_word   <= tx_cmd_pkg::WORD_RST;
      fifo_data_valid <= 1'b0;
      fifo_data_word  <= tx_cmd_pkg::WORD_RST;
      fifo_byte_en    <= 4'h0;
    end else begin
      fifo_cmd_valid  <= 1'b0;
      fifo_data_valid <= 1'b0;
      if (word_valid) begin
        if (state == S_CMDA) begin
          fifo_cmd_valid <= 1'b1;
          fifo_cmd_word  <= word;
        end
        if (state == S_CMDB && cmd_a[tx_cmd_pkg::A_FIRST_BIT]) begin
          fifo_cmd_valid <= 1'b1;
          fifo_cmd_word  <= word;
        end
        if (state == S_DATA) begin
          fifo_data_valid <= 1'b1;
          fifo_data_word  <= word;
          fifo_byte_en    <= lane_en;
        end
      end
    end
  end

  // per-packet controls from command B
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pkt_len     <= tx_cmd_pkg::LEN_RST;
      status_tag  <= tx_cmd_pkg::TAG_RST;
      crc_disable <= 1'b0;
      pad_disable <= 1'b0;
    end else if (word_valid && state == S_CMDB && cmd_a[tx_cmd_pkg::A_FIRST_BIT]) begin
      pkt_len     <= word[tx_cmd_pkg::B_LEN_HI:tx_cmd_pkg::B_LEN_LO];
      status_tag  <= word[tx_cmd_pkg::B_TAG_HI:tx_cmd_pkg::B_TAG_LO];
      // no padding still means the crc is added
      pad_disable <= word[tx_cmd_pkg::B_NOPAD_BIT];
      crc_disable <= word[tx_cmd_pkg::B_NOCRC_BIT] && !word[tx_cmd_pkg::B_NOPAD_BIT];
    end
  end

  // segment flags, running length and fifo usage
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      first_segment_flag <= 1'b0;
      last_segment_flag  <= 1'b0;
      len_sum            <= 12'd0;
      fifo_used          <= 12'd0;
    end else if (word_valid) begin
      if (state == S_CMDA) begin
        first_segment_flag <= word[tx_cmd_pkg::A_FIRST_BIT];
        last_segment_flag  <= word[tx_cmd_pkg::A_LAST_BIT];
        if (word[tx_cmd_pkg::A_FIRST_BIT]) begin
          len_sum   <= 12'(word[tx_cmd_pkg::A_SIZE_HI:tx_cmd_pkg::A_SIZE_LO]);
          fifo_used <= 12'd0;
        end else begin
          len_sum <= len_sum + 12'(word[tx_cmd_pkg::A_SIZE_HI:tx_cmd_pkg::A_SIZE_LO]);
        end
      end
      // whole words count, so partial lanes add up to 6 bytes per buffer
      if (state == S_DATA) fifo_used <= fifo_used + 12'd4;
    end
  end

  // end-of-buffer events
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      frame_end           <= 1'b0;
      transmit_done_flag  <= 1'b0;
      transmit_error_flag <= 1'b0;
      oversize_flag       <= 1'b0;
    end else begin
      frame_end          <= 1'b0;
      transmit_done_flag <= 1'b0;
      if (word_valid && state != S_CMDA && next_is_cmda()) begin
        transmit_done_flag <= cmd_a[tx_cmd_pkg::A_IOC_BIT];
        if (cmd_a[tx_cmd_pkg::A_LAST_BIT]) begin
          frame_end <= 1'b1;
          if (len_sum != 12'(pkt_len)) transmit_error_flag <= 1'b1;
        end
      end
      if (store_forward_select && fifo_used > SF_LIMIT) oversize_flag <= 1'b1;
    end
  end

  // true when the current word closes the buffer
  function automatic logic next_is_cmda();
    logic r;
    r = 1'b0;
    unique case (state)
      S_CMDB: r = (skip_cnt == 3'd0) && (bytes_left == 11'd0) && (fill_words == 4'd0);
      S_SKIP: r = (skip_cnt == 3'd1) && (bytes_left == 11'd0) && (fill_cnt == 4'd0);
      S_DATA: r = (bytes_left == 11'(lane_cnt)) && (fill_cnt == 4'd0);
      S_FILL: r = (fill_cnt == 4'd1);
      default: r = 1'b0;
    endcase
    next_is_cmda = r;
  endfunction : next_is_cmda

endmodule : tx_buffer_command_parser

//--- dv/tx_parser_properties.sv
/* port properties of the transmit buffer parser.
   assumes binding to tx_buffer_command_parser, single clk domain. */
`timescale 1ns/10ps
module tx_parser_props (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        host_wr,
  input wire logic        fifo_cmd_valid,
  input wire logic        fifo_data_valid,
  input wire logic [3:0]  fifo_byte_en,
  input wire logic        frame_end,
  input wire logic        crc_disable,
  input wire logic        pad_disable,
  input wire logic [15:0] status_tag,
  input wire logic        transmit_error_flag,
  input wire logic        transmit_done_flag,
  input wire logic        first_segment_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_data_beat;
    fifo_data_valid ##1 !fifo_data_valid;
  endsequence
  a_data_after_pair: assert property (fifo_data_valid |-> $past(host_wr, 2))
    else $error("data word without a host pair");
  a_cmd_after_pair: assert property (fifo_cmd_valid |-> $past(host_wr, 2))
    else $error("command word without a host pair");
  a_data_pulse: assert property (fifo_data_valid |-> s_data_beat)
    else $error("data valid longer than one cycle");
  a_valid_apart: assert property (!(fifo_cmd_valid && fifo_data_valid))
    else $error("command and data out together");
  a_lane_contig: assert property (fifo_data_valid |-> fifo_byte_en inside
    {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h6, 4'hc, 4'h7, 4'he, 4'hf})
    else $error("byte enables not contiguous");
  a_pad_keeps_crc: assert property (pad_disable |-> !crc_disable)
    else $error("crc dropped with padding off");
  a_err_sticky: assert property (transmit_error_flag |=> transmit_error_flag)
    else $error("length error flag cleared");
  a_end_on_word: assert property ((transmit_done_flag || frame_end) |-> $past(host_wr, 2))
    else $error("done or frame end without a word");
  a_done_pulse: assert property (transmit_done_flag |=> !transmit_done_flag)
    else $error("done flag longer than one cycle");
  a_seg_on_cmd: assert property ($changed(first_segment_flag) |-> fifo_cmd_valid)
    else $error("segment flag moved off a command");
  a_tag_on_cmd: assert property ($changed(status_tag) |-> fifo_cmd_valid)
    else $error("tag moved off a command");
endmodule : tx_parser_props

bind tx_buffer_command_parser tx_parser_props u_props (
  .clk, .nrst, .host_wr, .fifo_cmd_valid, .fifo_data_valid, .fifo_byte_en, .frame_end,
  .crc_disable, .pad_disable, .status_tag, .transmit_error_flag, .transmit_done_flag,
  .first_segment_flag
);

//--- dv/host_model.sv
/* host side model: writes 32-bit buffer words as 16-bit write pairs.
   assumes clk from the bench, which calls put_word and rest. */
`timescale 1ns/10ps
module host_model (
  input  wire logic        clk,
  output logic             host_wr,
  output logic [15:0]      host_data
);
  initial begin
    host_wr   = 1'b0;
    host_data = 16'h0000;
  end
  // low half first; no gap, so words may follow back to back
  task automatic put_word(input logic [31:0] w);
    @(posedge clk);
    host_wr   <= 1'b1;
    host_data <= w[15:0];
    @(posedge clk);
    host_data <= w[31:16];
  endtask : put_word
  // released bus shows the inverse, never a stale copy
  task automatic rest();
    @(posedge clk);
    host_wr   <= 1'b0;
    host_data <= ~host_data;
  endtask : rest
endmodule : host_model

//--- dv/tb_top.sv
/* self-checking bench of the transmit buffer parser.
   assumes host_model and the bound checker are compiled before it. */
`timescale 1ns/10ps
module tb_top;
  logic        clk, nrst, sfs, host_wr, cmd_v, data_v, frame_end, crc_disable, pad_disable;
  logic        transmit_error_flag, transmit_done_flag, first_segment_flag;
  logic        last_segment_flag, oversize_flag;
  logic [15:0] host_data, status_tag;
  logic [31:0] cmd_w, data_w;
  logic [3:0]  byte_en;
  logic [31:0] cq[$];
  logic [35:0] dq[$];
  int          fails, n_tests, n_done, x_done, n_end, x_end, nbuf, i;

  host_model u_host (.clk, .host_wr, .host_data);
  tx_buffer_command_parser dut (.clk, .nrst, .host_wr, .host_data,
    .store_forward_select(sfs), .fifo_cmd_valid(cmd_v), .fifo_cmd_word(cmd_w),
    .fifo_data_valid(data_v), .fifo_data_word(data_w), .fifo_byte_en(byte_en), .frame_end,
    .crc_disable, .pad_disable, .status_tag, .transmit_error_flag, .transmit_done_flag,
    .first_segment_flag, .last_segment_flag, .oversize_flag);

  always #20 clk = ~clk;

  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk

  task automatic finish_test();
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  // watcher: takes the oldest note whenever a word leaves
  always @(negedge clk) begin
    if (cmd_v === 1'b1) chk({4'h0, cmd_w}, cq.size() ? {4'h0, cq.pop_front()} : 'x);
    if (data_v === 1'b1) chk({byte_en, data_w}, dq.size() ? dq.pop_front() : 'x);
    if (transmit_done_flag === 1'b1) n_done++;
    if (frame_end === 1'b1) n_end++;
  end

  task automatic send_pkt(input int nb, input int bad, input int big);
    int          sz[8];
    int          len, b, k, off, al, np, n;
    logic [31:0] a, bw, w;
    logic [3:0]  en;
    len = 0;
    for (b = 0; b < nb; b++) begin
      sz[b] = (b > 0 && b < nb - 1) ? 4 + $urandom % 37 : 1 + $urandom % 40;
      if (big != 0) sz[b] = 2040;
      len += sz[b];
    end
    bw = {16'($urandom), 2'b00, 2'($urandom), 1'b0, 11'(len + bad)};
    for (b = 0; b < nb; b++) begin
      off = ($urandom % 8) * 4 + nbuf % 4;
      al = nbuf % 3;
      nbuf++;
      np = (off % 4 + sz[b] + 3) / 4;
      a = {1'($urandom), 5'h00, 2'(al), 3'h0, 5'(off), 2'h0, b == 0, b == nb - 1, 1'b0,
           11'(sz[b])};
      x_done += a[31];
      cq.push_back(a);
      u_host.put_word(a);
      if (b == 0) cq.push_back(bw);
      u_host.put_word(bw);
      for (k = 0; k < off / 4; k++) u_host.put_word($urandom);
      for (k = 0; k < np; k++) begin
        w = $urandom;
        en = 4'hf;
        if (k == 0) en = en << (off % 4);
        if (k == np - 1) en = en & (4'hf >> (3 - (off % 4 + sz[b] - 1) % 4));
        dq.push_back({en, w});
        u_host.put_word(w);
      end
      // filler counts the two command words toward alignment
      for (n = 2 + off / 4 + np; n % (al == 2 ? 8 : al == 1 ? 4 : 1) != 0; n++)
        u_host.put_word($urandom);
    end
    u_host.rest();
    x_end++;
    repeat (4) @(posedge clk);
    #1;
    chk(36'(cq.size() + dq.size()), 36'h0_0000_0000);
    chk({35'h0, transmit_error_flag}, 36'(bad != 0));
    chk({status_tag, crc_disable, pad_disable}, {bw[31:16], bw[13] & !bw[12], bw[12]});
    chk({first_segment_flag, last_segment_flag}, {nb == 1, 1'b1});
    chk({oversize_flag, 35'(n_done)}, {big != 0, 35'(x_done)});
    chk(36'(n_end), 36'(x_end));
  endtask : send_pkt

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    finish_test();
  end

  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    sfs = 1'b1;
    void'($urandom(32'h5f4d));
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    for (i = 0; i < 12; i++) send_pkt(1 + i % 3, 0, 0);
    send_pkt(3, 1, 0);
    // oversize is sticky, so the overlong packet runs last
    send_pkt(1, 1, 1);
    finish_test();
  end
endmodule : tb_top
